/* File: verilog/frame_number_offset_mapper.sv */
`timescale 1ns/1ns
module frame_number_offset_mapper #(
	parameter int FRAME_TICKS = fn_map_pkg::FRAME_CYCLES
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Link timing outputs
	output logic [7:0] conn_frame_number,
	output logic [7:0] link_frame_shift,
	output logic [15:0] link_chip_shift,
	output logic frame_tick
);

	// ----------------------------------------
	// Local sizes
	// ----------------------------------------
	localparam int FN_W = fn_map_pkg::CONN_FN_W;
	localparam int CELL_W = fn_map_pkg::CELL_FN_W;
	localparam int CHIP_W = fn_map_pkg::CHIP_W;
	localparam int DEF_W = fn_map_pkg::DEF_SHIFT_W;
	localparam int CHIPS_W = fn_map_pkg::DEF_SHIFT_W + fn_map_pkg::DEF_STEP_LOG2;
	// One spare bit so the last count never wraps early
	localparam int TICK_W = $clog2(FRAME_TICKS) + 1;
	localparam int OFFSET_W = 8;

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	// Modulo 256 sum of two frame numbers
	function automatic logic [FN_W-1:0] wrap_add(input logic [FN_W-1:0] a,
		input logic [FN_W-1:0] b);
		wrap_add = FN_W'(a + b);
	endfunction

	// Modulo 256 difference, a borrow adds 256
	function automatic logic [FN_W-1:0] wrap_sub(input logic [FN_W-1:0] a,
		input logic [FN_W-1:0] b);
		wrap_sub = FN_W'(a - b);
	endfunction

	// Register offset within the block
	function automatic logic [OFFSET_W-1:0] reg_offset(input logic [31:0] addr);
		reg_offset = addr[OFFSET_W-1:0];
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	// Control
	logic dedicated_q;
	logic dedicated_d;
	logic link_up_q;
	logic link_up_d;
	logic [DEF_W-1:0] def_shift_q;
	logic [DEF_W-1:0] def_shift_d;
	// Counters
	logic [CELL_W-1:0] cell_fn_q;
	logic [CELL_W-1:0] cell_fn_d;
	logic [FN_W-1:0] conn_fn_q;
	logic [FN_W-1:0] conn_fn_d;
	logic [FN_W-1:0] conn_fn_in_q;
	logic [FN_W-1:0] conn_fn_in_d;
	// Frame tick
	logic [TICK_W-1:0] tick_cnt_q;
	logic [TICK_W-1:0] tick_cnt_d;
	logic tick_q;
	logic tick_d;
	// Link shifts and frame mapping
	fn_map_pkg::link_shift_t shift_q;
	fn_map_pkg::link_shift_t shift_d;
	fn_map_pkg::frame_map_t map_q;
	fn_map_pkg::frame_map_t map_d;
	// Bus pipeline
	logic ap_wr_q;
	logic ap_wr_d;
	logic [OFFSET_W-1:0] ap_addr_q;
	logic [OFFSET_W-1:0] ap_addr_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;

	// ----------------------------------------
	// Combinational helpers
	// ----------------------------------------
	logic take;
	logic [CHIPS_W-1:0] def_chips;
	logic [FN_W-1:0] split_frame;
	logic [CHIP_W-1:0] split_chip;
	logic [DEF_W-1:0] def_wr;
	logic [FN_W-1:0] low_cell;

	// ----------------------------------------
	// Bus address phase
	// ----------------------------------------
	always_comb
	begin
		take = hsel && hready && htrans == fn_map_pkg::HTRANS_NONSEQ;
		ap_wr_d = take && hwrite;
		ap_addr_d = take ? reg_offset(haddr) : ap_addr_q;
	end

	// ----------------------------------------
	// Split of the default shift
	// ----------------------------------------
	always_comb
	begin
		def_chips = CHIPS_W'({def_shift_q, {fn_map_pkg::DEF_STEP_LOG2{1'b0}}});
		split_frame = FN_W'(def_chips / CHIPS_W'(fn_map_pkg::CHIPS_PER_FRAME));
		split_chip = CHIP_W'(def_chips % CHIPS_W'(fn_map_pkg::CHIPS_PER_FRAME));
		low_cell = cell_fn_q[FN_W-1:0];
		def_wr = hwdata[DEF_W-1:0];
	end

	// ----------------------------------------
	// Frame tick
	// ----------------------------------------
	always_comb
	begin
		tick_d = 1'b0;
		tick_cnt_d = TICK_W'(tick_cnt_q + TICK_W'(1));
		if (tick_cnt_q == TICK_W'(FRAME_TICKS - 1))
		begin
			tick_cnt_d = '0;
			tick_d = 1'b1;
		end
	end

	// ----------------------------------------
	// Counters and register writes
	// ----------------------------------------
	always_comb
	begin
		dedicated_d = dedicated_q;
		link_up_d = link_up_q;
		def_shift_d = def_shift_q;
		cell_fn_d = cell_fn_q;
		conn_fn_in_d = conn_fn_in_q;
		conn_fn_d = conn_fn_q;
		// The cell counter advances on the frame tick, the connection counter only while link up is set
		if (tick_q)
		begin
			cell_fn_d = CELL_W'(cell_fn_q + CELL_W'(1));
			if (link_up_q)
				conn_fn_d = wrap_add(conn_fn_q, FN_W'(1));
		end
		// A write in the tick cycle wins over the count
		if (ap_wr_q)
		begin
			unique case (ap_addr_q)
				fn_map_pkg::ADDR_CTRL:
				begin
					dedicated_d = hwdata[fn_map_pkg::CTRL_DEDICATED_BIT];
					link_up_d = hwdata[fn_map_pkg::CTRL_LINK_UP_BIT];
					if (hwdata[fn_map_pkg::CTRL_LOAD_BIT])
						conn_fn_d = conn_fn_in_q;
				end
				fn_map_pkg::ADDR_DEF_SHIFT:
				begin
					// Values past the top step saturate
					if (def_wr > fn_map_pkg::DEF_SHIFT_MAX)
						def_shift_d = fn_map_pkg::DEF_SHIFT_MAX;
					else
						def_shift_d = def_wr;
				end
				fn_map_pkg::ADDR_CELL_FN:
					cell_fn_d = hwdata[CELL_W-1:0];
				fn_map_pkg::ADDR_CONN_FN_IN:
					conn_fn_in_d = hwdata[FN_W-1:0];
				default:
				begin
				end
			endcase
		end
	end

	// ----------------------------------------
	// Link shifts and frame mapping
	// ----------------------------------------
	always_comb
	begin
		if (dedicated_q)
		begin
			shift_d.frame = split_frame;
			shift_d.chip = split_chip;
		end
		else
		begin
			shift_d.frame = '0;
			shift_d.chip = '0;
		end
		map_d.cell_from_conn = wrap_sub(conn_fn_q, shift_q.frame);
		map_d.conn_from_cell = wrap_add(low_cell, shift_q.frame);
	end

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	// Loaded at the address phase edge, stands in the data phase
	always_comb
	begin
		rdata_d = 32'h0;
		if (take && !hwrite)
		begin
			unique case (reg_offset(haddr))
				fn_map_pkg::ADDR_CTRL:
				begin
					rdata_d[fn_map_pkg::CTRL_DEDICATED_BIT] = dedicated_q;
					rdata_d[fn_map_pkg::CTRL_LINK_UP_BIT] = link_up_q;
				end
				fn_map_pkg::ADDR_DEF_SHIFT:
					rdata_d = 32'(def_shift_q);
				fn_map_pkg::ADDR_CELL_FN:
					rdata_d = 32'(cell_fn_q);
				fn_map_pkg::ADDR_CONN_FN_IN:
					rdata_d = 32'(conn_fn_in_q);
				fn_map_pkg::ADDR_SHIFT:
					rdata_d = 32'(shift_q.frame)
						| (32'(shift_q.chip) << fn_map_pkg::SHIFT_CHIP_LSB);
				fn_map_pkg::ADDR_MAP:
					rdata_d = 32'({map_q.conn_from_cell, map_q.cell_from_conn});
				fn_map_pkg::ADDR_CONN_CNT:
					rdata_d = 32'(conn_fn_q);
				default:
					rdata_d = 32'h0;
			endcase
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ap_wr_q <= 1'b0;
			ap_addr_q <= '0;
			rdata_q <= 32'h0;
			dedicated_q <= 1'b0;
			link_up_q <= 1'b0;
			def_shift_q <= '0;
			cell_fn_q <= '0;
			conn_fn_in_q <= '0;
			conn_fn_q <= '0;
			shift_q <= '0;
			tick_cnt_q <= '0;
			tick_q <= 1'b0;
			map_q <= '0;
		end
		else
		begin
			ap_wr_q <= ap_wr_d;
			ap_addr_q <= ap_addr_d;
			rdata_q <= rdata_d;
			dedicated_q <= dedicated_d;
			link_up_q <= link_up_d;
			def_shift_q <= def_shift_d;
			cell_fn_q <= cell_fn_d;
			conn_fn_in_q <= conn_fn_in_d;
			conn_fn_q <= conn_fn_d;
			shift_q <= shift_d;
			tick_cnt_q <= tick_cnt_d;
			tick_q <= tick_d;
			map_q <= map_d;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Zero wait states, always an OKAY response
	assign hrdata = rdata_q;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign conn_frame_number = conn_fn_q;
	assign link_frame_shift = shift_q.frame;
	assign link_chip_shift = shift_q.chip;
	assign frame_tick = tick_q;

endmodule // frame_number_offset_mapper

/* File: verilog/fn_map_pkg.sv */
package fn_map_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_DEF_SHIFT = 8'h04;
	localparam logic [7:0] ADDR_CELL_FN = 8'h08;
	localparam logic [7:0] ADDR_CONN_FN_IN = 8'h0c;
	localparam logic [7:0] ADDR_SHIFT = 8'h10;
	localparam logic [7:0] ADDR_MAP = 8'h14;
	localparam logic [7:0] ADDR_CONN_CNT = 8'h18;

	// ----------------------------------------
	// Field layout and limits
	// ----------------------------------------
	localparam int CTRL_DEDICATED_BIT = 0;
	localparam int CTRL_LOAD_BIT = 1;
	localparam int CTRL_LINK_UP_BIT = 2;
	localparam int CONN_FN_W = 8;
	localparam int CELL_FN_W = 12;
	localparam int CHIP_W = 16;
	localparam int DEF_SHIFT_W = 10;
	localparam int SHIFT_CHIP_LSB = 16;
	localparam logic [CHIP_W-1:0] CHIPS_PER_FRAME = 16'h9600;
	localparam logic [DEF_SHIFT_W-1:0] DEF_SHIFT_MAX = 10'h257;
	localparam int DEF_STEP_LOG2 = 9;
	localparam int FRAME_TIME_NS = 10000000;
	localparam int CLK_PERIOD_NS = 100;
	localparam int FRAME_CYCLES = FRAME_TIME_NS / CLK_PERIOD_NS;

	// ----------------------------------------
	// AHB encodings
	// ----------------------------------------
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD = 3'h2;

	typedef struct packed {
		logic [CONN_FN_W-1:0] frame;
		logic [CHIP_W-1:0] chip;
	} link_shift_t;

	typedef struct packed {
		logic [CONN_FN_W-1:0] cell_from_conn;
		logic [CONN_FN_W-1:0] conn_from_cell;
	} frame_map_t;

endpackage

/* File: tb/fn_map_monitor.sv */
`timescale 1ns/1ns
module fn_map_monitor #(
	parameter int FRAME_TICKS = 20
) (
	// Clock, reset and bus
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [1:0] htrans,
	input wire logic hreadyout,
	input wire logic hresp,
	// Link timing
	input wire logic [7:0] conn_frame_number,
	input wire logic [7:0] link_frame_shift,
	input wire logic [15:0] link_chip_shift,
	input wire logic frame_tick
);
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	logic [2:0] busy_q;
	logic [31:0] total;
	// Recent bus requests, newest in bit 0
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			busy_q <= 3'h0;
		else
			busy_q <= {busy_q[1:0], htrans == fn_map_pkg::HTRANS_NONSEQ};
	end
	assign total = link_frame_shift * 32'd38400 + link_chip_shift;
	// Cycles since the last tick
	logic [31:0] gap_q;
	logic seen_q;
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			gap_q <= 32'h0;
			seen_q <= 1'b0;
		end
		else if (frame_tick)
		begin
			gap_q <= 32'h0;
			seen_q <= 1'b1;
		end
		else
			gap_q <= gap_q + 32'h1;
	end
	sequence s_tick_drop;
		##1 !frame_tick;
	endsequence
	a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not ready or okay");
	a_chip_range: assert property (link_chip_shift <= 16'd38399)
		else $error("chip shift out of range");
	a_shift_form: assert property (total % 512 == 0 && total <= 32'd306688)
		else $error("shifts not a default shift multiple");
	a_tick_pulse: assert property (frame_tick |-> s_tick_drop) else $error("tick too long");
	a_tick_period: assert property (frame_tick && seen_q |-> gap_q == 32'(FRAME_TICKS - 1))
		else $error("tick period wrong");
	a_cfn_step: assert property ($past(hresetn) && busy_q[1:0] == 2'h0
		&& $changed(conn_frame_number) |-> conn_frame_number == $past(conn_frame_number) + 8'h1)
		else $error("counter step not one");
	a_cfn_quiet: assert property ($past(hresetn) && busy_q[1:0] == 2'h0 && !$past(frame_tick)
		&& !$past(frame_tick, 2) |-> $stable(conn_frame_number))
		else $error("counter moved without tick");
	a_shift_quiet: assert property ($past(hresetn) && busy_q == 3'h0
		|-> $stable(link_frame_shift) && $stable(link_chip_shift))
		else $error("shift moved without write");
endmodule // fn_map_monitor

/* File: tb/ctrl_default_chip_shift_512_model.sv */
`timescale 1ns/1ns
module ctrl_handset_model (
	// Selection and observed counters
	input wire logic [2:0] idx,
	input wire logic [11:0] cell_fn,
	input wire logic [7:0] conn_fn,
	// Controller side: default shift in 512-chip steps
	output logic [9:0] def_shift,
	// Handset side
	output logic [7:0] init_conn_fn,
	output logic [7:0] frame_diff,
	output logic [15:0] chip_diff
);
	logic [31:0] chips;
	always_comb
	begin
		case (idx)
			3'h0: def_shift = 10'h000;
			3'h1: def_shift = 10'h001;
			3'h2: def_shift = 10'h04b;
			3'h3: def_shift = 10'h04c;
			default: def_shift = 10'h257;
		endcase
		// First link: whole frames of cell time plus default shift, mod 256
		chips = 32'(cell_fn) * 32'h9600 + 32'(def_shift) * 32'h200;
		init_conn_fn = 8'(chips / 32'h9600);
		// Frame difference to a cell, mod 256, 0 to 255
		frame_diff = 8'(conn_fn - cell_fn[7:0]);
		// One link from common state: zero chip difference
		chip_diff = 16'h0000;
	end
endmodule // ctrl_handset_model

/* File: tb/frame_number_offset_mapper_tb.sv */
`timescale 1ns/1ns
module frame_number_offset_mapper_tb;
	localparam int FRAME_TICKS = 40;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = fn_map_pkg::HSIZE_WORD;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic frame_tick;
	logic [7:0] conn_frame_number;
	logic [7:0] link_frame_shift;
	logic [15:0] link_chip_shift;
	logic [2:0] idx = 3'h0;
	logic [11:0] cell_fn = 12'h000;
	logic [9:0] def_shift;
	logic [7:0] init_conn_fn;
	logic [7:0] frame_diff;
	logic [15:0] chip_diff;
	logic [31:0] r;
	int fails = 0;
	int comparisons = 0;
	int cycles = 0;
	int c;
	always #50 hclk = ~hclk;
	ctrl_handset_model i_ctrl (.idx(idx), .cell_fn(cell_fn), .conn_fn(conn_frame_number),
		.def_shift(def_shift), .init_conn_fn(init_conn_fn), .frame_diff(frame_diff),
		.chip_diff(chip_diff));
	frame_number_offset_mapper #(.FRAME_TICKS(FRAME_TICKS)) i_dut (.hclk(hclk),
		.hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .conn_frame_number(conn_frame_number),
		.link_frame_shift(link_frame_shift), .link_chip_shift(link_chip_shift),
		.frame_tick(frame_tick));
	// ----------------------------------------
	// Bus, check and tick tasks
	// ----------------------------------------
	task print_verdict;
		$display("fails=%0d comparisons=%0d", fails, comparisons);
		if (fails == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		hwrite <= w;
		haddr <= {24'h0, a};
		htrans <= fn_map_pkg::HTRANS_NONSEQ;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		comparisons++;
		if (r !== e)
		begin
			fails++;
			$display("BAD %0t read %h got %h want %h", $time, a, r, e);
		end
	endtask
	task chk(input logic [31:0] got, input logic [31:0] want);
		comparisons++;
		if (got !== want)
		begin
			fails++;
			$display("BAD %0t pin got %h want %h", $time, got, want);
		end
	endtask
	task tick(input int n);
		repeat (n) do @(posedge hclk); while (frame_tick !== 1'b1);
	endtask
	initial
	begin
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(fn_map_pkg::ADDR_SHIFT, 32'h0);
		rd(fn_map_pkg::ADDR_CONN_CNT, 32'h0);
		xfer(1'b1, fn_map_pkg::ADDR_DEF_SHIFT, 32'h3ff);
		rd(fn_map_pkg::ADDR_DEF_SHIFT, 32'h257);
		xfer(1'b1, 8'h1c, 32'h5);
		rd(8'h1c, 32'h0);
		for (int i = 0; i < 5; i++)
		begin
			idx <= i[2:0];
			@(posedge hclk);
			c = int'(def_shift) * 512;
			xfer(1'b1, fn_map_pkg::ADDR_DEF_SHIFT, {22'h0, def_shift});
			xfer(1'b1, fn_map_pkg::ADDR_CTRL, 32'h1);
			repeat (2) @(posedge hclk);
			rd(fn_map_pkg::ADDR_SHIFT, {16'(c % 38400), 8'h0, 8'(c / 38400)});
			chk({16'h0, link_chip_shift}, 32'(c % 38400));
			chk({24'h0, link_frame_shift}, 32'(c / 38400));
		end
		xfer(1'b1, fn_map_pkg::ADDR_CTRL, 32'h0);
		repeat (2) @(posedge hclk);
		rd(fn_map_pkg::ADDR_SHIFT, 32'h0);
		chk({8'h0, link_chip_shift, link_frame_shift}, 32'h0);
		tick(1);
		cell_fn <= 12'hffe;
		xfer(1'b1, fn_map_pkg::ADDR_CELL_FN, 32'hffe);
		xfer(1'b1, fn_map_pkg::ADDR_CONN_FN_IN, {24'h0, init_conn_fn});
		xfer(1'b1, fn_map_pkg::ADDR_CTRL, 32'h3);
		repeat (3) @(posedge hclk);
		rd(fn_map_pkg::ADDR_MAP, 32'h05fe);
		chk({24'h0, conn_frame_number}, 32'h05);
		chk({24'h0, frame_diff}, {24'h0, link_frame_shift});
		tick(1);
		xfer(1'b1, fn_map_pkg::ADDR_CELL_FN, 32'hfff);
		xfer(1'b1, fn_map_pkg::ADDR_CONN_FN_IN, 32'hfe);
		xfer(1'b1, fn_map_pkg::ADDR_CTRL, 32'h7);
		tick(3);
		repeat (2) @(posedge hclk);
		rd(fn_map_pkg::ADDR_CONN_CNT, 32'h01);
		chk({24'h0, conn_frame_number}, 32'h01);
		rd(fn_map_pkg::ADDR_CELL_FN, 32'h002);
		xfer(1'b1, fn_map_pkg::ADDR_CTRL, 32'h1);
		tick(2);
		repeat (2) @(posedge hclk);
		rd(fn_map_pkg::ADDR_CONN_CNT, 32'h01);
		print_verdict;
	end
	always @(posedge hclk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			fails++;
			$display("BAD %0t run too long", $time);
			print_verdict;
		end
	end
endmodule // frame_number_offset_mapper_tb
bind frame_number_offset_mapper fn_map_monitor #(.FRAME_TICKS(FRAME_TICKS)) i_mon (.hclk,
	.hresetn, .htrans, .hreadyout, .hresp, .conn_frame_number, .link_frame_shift,
	.link_chip_shift, .frame_tick);
